// >>> hdl/ppds_pkg.sv
// Purpose: shared constants of the printer port data and status path
// Assumes: 10 MHz system clock, byte-wide host port with two address bits
// Notes: data, control and bus reset values and field positions live here

package ppds_pkg;

    // ----------------------------------------------------------------
    // register selection
    // ----------------------------------------------------------------
    localparam logic [1:0] ADDR_DATA = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_NONE = 2'h3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [7:0] BUS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_IRQ_EN = 4;
    localparam int CTRL_DIR = 5;
    localparam int CTRL_PIN_TOP = 3;
    localparam int SYNC_ERR = 0;
    localparam int SYNC_ACK = 3;
    localparam int SYNC_BUSY = 4;
    localparam int STS_W = 5;
    localparam logic [1:0] CTRL_RSVD_READ = 2'h3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TMO_MIN_NS = 10000;
    // least time, so round up
    localparam int TMO_CYCLES = (TMO_MIN_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
    localparam int TMO_CNT_W = 7;
    localparam logic [TMO_CNT_W-1:0] TMO_LAST = 7'(TMO_CYCLES - 1);
    localparam logic [TMO_CNT_W-1:0] TMO_ONE = 7'h01;
    localparam logic [TMO_CNT_W-1:0] TMO_ZERO = 7'h00;

endpackage : ppds_pkg

// >>> hdl/ppds_top.sv
// Purpose: data, status and control registers of a 1284 printer port
// Assumes: host strobes are one-cycle pulses on clk; pins are asynchronous
// Notes: read data appears one cycle after the read strobe
//
// Overview of operation
// RL1: address 0 data, 1 status, 2 control, 3 none
// RL2: setup select bit picks compatible or extended
// RL3: compatible write drives pins, read returns latch
// RL4: extended write latches; pins driven only direction 0
// RL5: extended read: latch if direction 0, pins else
// RL6: select low keeps data pins output only
// RL7: data register is eight bits, reset zero
// RL8: status writes change nothing
// RL9: epp timeout sets status bit zero, 10 us
// RL10: status read clears the timeout flag
// RL11: epp enable rising clears the timeout flag
// RL12: outside epp status bit zero reads one
// RL13: status bit one always reads one
// RL14: status bit two constant or interrupt status
// RL15: acknowledge rise latches bit two low; read restores
// RL16: status bits three to six follow inputs
// RL17: status bit seven is inverted busy
// RL18: printer pulses acknowledge low, drives busy
// RL19: control bit five is direction, resets output
// RL20: cfg bit zero enables epp, bit one revision
// RL21: printer inputs pass two flip-flops first

`timescale 1ns/1ns
`default_nettype none

module ppds_top (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // host register port
    input wire logic [1:0] hostAddr,
    input wire logic hostRd,
    input wire logic hostWr,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] hostDataOut,
    output logic hostDataOe,
    // configuration bits held elsewhere
    input wire logic extModeSel,
    input wire logic eppEnable,
    input wire logic eppRevSel,
    input wire logic ecpEnable,
    input wire logic cfgIrqStatusEn,
    // epp sequencer
    input wire logic eppWaitActive,
    output logic eppRev19,
    // printer data pins
    input wire logic [7:0] pdataPinsIn,
    output logic [7:0] pdataPinsOut,
    output logic pdataPinsOe,
    // printer status pins
    input wire logic errIn,
    input wire logic selectedIn,
    input wire logic paperOutIn,
    input wire logic ackIn,
    input wire logic busyIn,
    // control latch towards the printer
    output logic [3:0] ctrlPinBits,
    output logic ackIrqEn
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [7:0] pinMeta;
    logic [7:0] pinSync;
    logic [ppds_pkg::STS_W-1:0] stsMeta;
    logic [ppds_pkg::STS_W-1:0] stsSync;
    logic ackPrev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= ppds_pkg::BUS_RESET;
            pinSync <= ppds_pkg::BUS_RESET;
            // ack idles high, so no false edge follows reset
            stsMeta <= '1;
            stsSync <= '1;
            ackPrev <= 1'b1;
        end else if (ce) begin
            pinMeta <= pdataPinsIn; // RL21
            pinSync <= pinMeta; // RL21
            stsMeta <= {busyIn, ackIn, paperOutIn, selectedIn, errIn};
            stsSync <= stsMeta; // RL21
            ackPrev <= stsSync[ppds_pkg::SYNC_ACK];
        end
    end

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    logic [5:0] ctrlReg;
    logic [7:0] dataLatch;
    logic dataDir;
    logic extDirIn;
    logic irqMode;
    logic ackRise;
    logic rdData;
    logic rdStatus;
    logic wrData;
    logic wrControl;

    assign dataDir = ctrlReg[ppds_pkg::CTRL_DIR]; // RL19
    // direction only counts in extended mode
    assign extDirIn = extModeSel & dataDir; // RL2 RL6
    // ecp or epp hand bit two to the config bit instead
    assign irqMode = (eppEnable | ecpEnable) ? cfgIrqStatusEn
                                            : extModeSel; // RL14
    // printer pulses ack low; the trailing edge is the event
    assign ackRise = stsSync[ppds_pkg::SYNC_ACK] & ~ackPrev; // RL18
    assign rdData = hostRd & (hostAddr == ppds_pkg::ADDR_DATA);
    assign rdStatus = hostRd & (hostAddr == ppds_pkg::ADDR_STATUS);
    assign wrData = hostWr & (hostAddr == ppds_pkg::ADDR_DATA);
    assign wrControl = hostWr & (hostAddr == ppds_pkg::ADDR_CONTROL); // RL8

    // ----------------------------------------------------------------
    // data register and pins
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataLatch <= ppds_pkg::DATA_RESET; // RL7
        end else if (ce && wrData) begin
            dataLatch <= hostDataIn; // RL3 RL4
        end
    end

    assign pdataPinsOut = dataLatch; // RL3

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pdataPinsOe <= 1'b1;
        end else if (ce) begin
            pdataPinsOe <= ~extDirIn; // RL4 RL6
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlReg <= ppds_pkg::CTRL_RESET; // RL19
        end else if (ce && wrControl) begin
            ctrlReg <= hostDataIn[5:0];
        end
    end

    assign ctrlPinBits = ctrlReg[ppds_pkg::CTRL_PIN_TOP:0];
    assign ackIrqEn = ctrlReg[ppds_pkg::CTRL_IRQ_EN];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eppRev19 <= 1'b0;
        end else if (ce) begin
            eppRev19 <= eppEnable & eppRevSel; // RL20
        end
    end

    // ----------------------------------------------------------------
    // epp timeout
    // ----------------------------------------------------------------
    logic [ppds_pkg::TMO_CNT_W-1:0] waitCnt;
    logic eppEnPrev;
    logic tmoFlag;
    logic tmoSet;
    logic tmoClear;

    // counts only while the sequencer waits on the peripheral
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt <= ppds_pkg::TMO_ZERO;
        end else if (ce) begin
            if (!eppWaitActive || !eppEnable) begin
                waitCnt <= ppds_pkg::TMO_ZERO;
            end else if (waitCnt != ppds_pkg::TMO_LAST) begin
                waitCnt <= waitCnt + ppds_pkg::TMO_ONE;
            end
        end
    end

    assign tmoSet = eppEnable & eppWaitActive &
                    (waitCnt == ppds_pkg::TMO_LAST); // RL9
    assign tmoClear = rdStatus | (eppEnable & ~eppEnPrev); // RL10 RL11

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eppEnPrev <= 1'b0;
        end else if (ce) begin
            eppEnPrev <= eppEnable;
        end
    end

    // a timeout in the clearing cycle still lands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmoFlag <= 1'b0;
        end else if (ce) begin
            if (tmoSet) begin
                tmoFlag <= 1'b1; // RL9
            end else if (tmoClear) begin
                tmoFlag <= 1'b0; // RL10 RL11
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, active low
    // ----------------------------------------------------------------
    logic irqStatus;
    logic irqLatch;

    assign irqLatch = irqMode & ackIrqEn & ackRise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus <= 1'b1;
        end else if (ce) begin
            if (irqLatch) begin
                irqStatus <= 1'b0; // RL15
            end else if (rdStatus) begin
                irqStatus <= 1'b1; // RL15
            end
        end
    end

    // ----------------------------------------------------------------
    // host read mux
    // ----------------------------------------------------------------
    logic [7:0] statusVal;
    logic [7:0] controlVal;
    logic [7:0] next_hostDataOut;

    assign statusVal = {~stsSync[ppds_pkg::SYNC_BUSY], // RL17
                        stsSync[ppds_pkg::SYNC_ACK:ppds_pkg::SYNC_ERR], // RL16
                        irqMode ? irqStatus : 1'b1, // RL14
                        1'b1, // RL13
                        eppEnable ? tmoFlag : 1'b1}; // RL12
    // direction reads back only under epp
    assign controlVal = {ppds_pkg::CTRL_RSVD_READ,
                         eppEnable ? dataDir : 1'b1,
                         ctrlReg[ppds_pkg::CTRL_IRQ_EN:0]};

    always_comb begin
        case (hostAddr) // RL1
            ppds_pkg::ADDR_DATA: begin
                next_hostDataOut = extDirIn ? pinSync : dataLatch; // RL5
            end
            ppds_pkg::ADDR_STATUS: begin
                next_hostDataOut = statusVal;
            end
            ppds_pkg::ADDR_CONTROL: begin
                next_hostDataOut = controlVal;
            end
            default: begin
                next_hostDataOut = ppds_pkg::BUS_RESET;
            end
        endcase
    end

    // bus stays released at address 3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hostDataOut <= ppds_pkg::BUS_RESET;
            hostDataOe <= 1'b0;
        end else if (ce) begin
            hostDataOe <= hostRd & (hostAddr != ppds_pkg::ADDR_NONE); // RL1
            if (hostRd) begin
                hostDataOut <= next_hostDataOut;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_undriven_addr: assert property ( // RL1
        @(posedge clk) disable iff (!rst_n)
        ce && hostRd && hostAddr == ppds_pkg::ADDR_NONE |=> !hostDataOe)
        else $error("bus driven at empty address");

    a_compat_pins_out: assert property ( // RL6
        @(posedge clk) disable iff (!rst_n)
        ce && !extModeSel |=> pdataPinsOe)
        else $error("pins not output in compatible mode");

    a_ext_dir_in: assert property ( // RL4
        @(posedge clk) disable iff (!rst_n)
        ce && extModeSel && dataDir |=> !pdataPinsOe)
        else $error("pins driven with direction in");

    a_data_write: assert property ( // RL3
        @(posedge clk) disable iff (!rst_n)
        ce && wrData |=> pdataPinsOut == $past(hostDataIn))
        else $error("data write not latched");

    a_ext_read_pins: assert property ( // RL5
        @(posedge clk) disable iff (!rst_n)
        ce && rdData && extDirIn |=> hostDataOut == $past(pinSync))
        else $error("extended read not from pins");

    a_status_fixed: assert property ( // RL13
        @(posedge clk) disable iff (!rst_n)
        ce && rdStatus |=> hostDataOut[1] && hostDataOe &&
        hostDataOut[7] == !$past(stsSync[ppds_pkg::SYNC_BUSY]))
        else $error("status fixed or busy bit wrong");

    a_status_follow: assert property ( // RL16
        @(posedge clk) disable iff (!rst_n)
        ce && rdStatus |=> hostDataOut[6:3] == $past(stsSync[3:0]))
        else $error("status does not follow inputs");

    a_nonepp_bit0: assert property ( // RL12
        @(posedge clk) disable iff (!rst_n)
        ce && rdStatus && !eppEnable |=> hostDataOut[0])
        else $error("bit zero not one outside epp");

    a_tmo_clear: assert property ( // RL10
        @(posedge clk) disable iff (!rst_n)
        ce && rdStatus && !tmoSet |=> !tmoFlag)
        else $error("timeout flag not cleared by read");

    a_tmo_time: assert property ( // RL9
        @(posedge clk) disable iff (!rst_n)
        ce && eppEnable && !tmoFlag && !eppWaitActive ##1
        (ce && eppEnable && eppWaitActive)[*8] |-> !tmoFlag)
        else $error("timeout flag set too early");

    a_epp_rise: assert property ( // RL11
        @(posedge clk) disable iff (!rst_n)
        ce && $rose(eppEnable) && !tmoSet |=> !tmoFlag)
        else $error("timeout flag kept over epp enable");

    a_irq_latch: assert property ( // RL15
        @(posedge clk) disable iff (!rst_n)
        ce && irqLatch |=> !irqStatus)
        else $error("acknowledge edge not latched");

    a_status_write: assert property ( // RL8
        @(posedge clk) disable iff (!rst_n)
        ce && hostWr && hostAddr == ppds_pkg::ADDR_STATUS |=>
        $stable(ctrlReg) && $stable(dataLatch))
        else $error("status write changed state");

endmodule : ppds_top

`default_nettype wire

// >>> dv/ppds_printer_model.sv
// Purpose: printer on the far side of the port
// Assumes: bench pulses printReq for one cycle per character
// Notes: drives the data wire only while the device has released it

`timescale 1ns/1ns
`default_nettype none

module ppds_printer_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench requests
    input wire logic printReq,
    input wire logic [7:0] periphByte,
    // device data drivers
    input wire logic [7:0] pdataPinsOut,
    input wire logic pdataPinsOe,
    // connector lines
    output logic [7:0] pdataWire,
    output logic ackIn,
    output logic busyIn
);
    // ----------------------------------------------------------------
    // character acceptance
    // ----------------------------------------------------------------
    logic [2:0] phase;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 3'h0;
        end else if (phase == 3'h5) begin
            phase <= 3'h0;
        end else if (phase != 3'h0 || printReq) begin
            phase <= phase + 3'h1;
        end
    end

    // busy in phases 1 to 3, ack low in phases 3 and 4
    assign busyIn = (phase != 3'h0) && (phase < 3'h4);
    assign ackIn = !(phase == 3'h3 || phase == 3'h4);
    assign pdataWire = pdataPinsOe ? pdataPinsOut : periphByte;
endmodule : ppds_printer_model

`default_nettype wire

// >>> dv/ppds_top_tb.sv
// Purpose: self-checking bench of the printer port registers
// Assumes: 10 MHz clock, host strobes one cycle wide
// Notes: pin values reach status after two synchroniser edges

`timescale 1ns/1ns
`default_nettype none

module ppds_top_tb;
    typedef struct packed {
        logic ext;
        logic [1:0] wAddr;
        logic [7:0] wData;
        logic [1:0] rAddr;
        logic [7:0] expRd;
        logic expOe;
        logic expPinOe;
    } ppds_row_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] hostAddr = 2'h0;
    logic hostRd = 1'b0;
    logic hostWr = 1'b0;
    logic [7:0] hostDataIn = 8'h00;
    logic extModeSel = 1'b0;
    logic eppEnable = 1'b0;
    logic eppRevSel = 1'b0;
    logic eppWaitActive = 1'b0;
    logic printReq = 1'b0;
    logic ce = 1'b1, ecpEnable = 1'b0, cfgIrqStatusEn = 1'b0;
    logic [7:0] hostDataOut, pdataPinsOut, pdataWire, d;
    logic [3:0] ctrlPinBits;
    logic hostDataOe, eppRev19, pdataPinsOe, ackIrqEn, ackIn, busyIn, oe;
    int testsRun = 0;
    int miscompares = 0;
    ppds_row_t rows [8];

    always #50 clk = ~clk;

    ppds_top ppds_top_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr),
        .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .extModeSel(extModeSel),
        .eppEnable(eppEnable), .eppRevSel(eppRevSel), .ecpEnable(ecpEnable),
        .cfgIrqStatusEn(cfgIrqStatusEn), .eppWaitActive(eppWaitActive),
        .eppRev19(eppRev19), .pdataPinsIn(pdataWire),
        .pdataPinsOut(pdataPinsOut), .pdataPinsOe(pdataPinsOe),
        .errIn(1'b1), .selectedIn(1'b1), .paperOutIn(1'b0), .ackIn(ackIn),
        .busyIn(busyIn), .ctrlPinBits(ctrlPinBits), .ackIrqEn(ackIrqEn));

    ppds_printer_model ppds_printer_model_i (.clk(clk), .rst_n(rst_n),
        .printReq(printReq), .periphByte(8'h3c),
        .pdataPinsOut(pdataPinsOut), .pdataPinsOe(pdataPinsOe),
        .pdataWire(pdataWire), .ackIn(ackIn), .busyIn(busyIn));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task giveVerdict;
        if (miscompares == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : giveVerdict

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task hostWrite(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        hostAddr <= a;
        hostDataIn <= v;
        hostWr <= 1'b1;
        @(posedge clk);
        hostWr <= 1'b0;
    endtask : hostWrite

    // data is registered one edge after the strobe
    task hostRead(input logic [1:0] a, output logic [7:0] v,
                  output logic o);
        @(posedge clk);
        hostAddr <= a;
        hostRd <= 1'b1;
        @(posedge clk);
        hostRd <= 1'b0;
        #1;
        v = hostDataOut;
        o = hostDataOe;
    endtask : hostRead

    task waitAck(input logic lvl);
        int n;
        n = 0;
        while (ackIn !== lvl && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            giveVerdict();
        end
    endtask : waitAck

    // one character through the printer, then time for the ack edge
    task printOne;
        @(posedge clk);
        printReq <= 1'b1;
        @(posedge clk);
        printReq <= 1'b0;
        waitAck(1'b0);
        waitAck(1'b1);
        repeat (4) @(posedge clk);
    endtask : printOne

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        giveVerdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rows[0] = '{1'b0, 2'h0, 8'ha5, 2'h0, 8'ha5, 1'b1, 1'b1};
        rows[1] = '{1'b0, 2'h2, 8'h20, 2'h0, 8'ha5, 1'b1, 1'b1};
        rows[2] = '{1'b0, 2'h2, 8'h20, 2'h2, 8'he0, 1'b1, 1'b1};
        rows[3] = '{1'b1, 2'h0, 8'h5a, 2'h0, 8'h3c, 1'b1, 1'b0};
        rows[4] = '{1'b1, 2'h2, 8'h00, 2'h0, 8'h5a, 1'b1, 1'b1};
        rows[5] = '{1'b1, 2'h1, 8'h00, 2'h1, 8'hdf, 1'b1, 1'b1};
        rows[6] = '{1'b0, 2'h3, 8'hff, 2'h3, 8'h00, 1'b0, 1'b1};
        rows[7] = '{1'b0, 2'h1, 8'h11, 2'h0, 8'h5a, 1'b1, 1'b1};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({hostDataOut}, 8'h00);
        chk({6'h0, pdataPinsOe, eppRev19}, 8'h02);
        chk({3'h0, ackIrqEn, ctrlPinBits}, 8'h00);
        hostRead(2'h0, d, oe);
        chk(d, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk);
            extModeSel <= rows[i].ext;
            hostWrite(rows[i].wAddr, rows[i].wData);
            repeat (3) @(posedge clk);
            hostRead(rows[i].rAddr, d, oe);
            chk(d, rows[i].expRd);
            chk({7'h0, oe}, {7'h0, rows[i].expOe});
            chk({7'h0, pdataPinsOe}, {7'h0, rows[i].expPinOe});
        end
        // acknowledge rise latches the interrupt status low
        @(posedge clk);
        extModeSel <= 1'b1;
        hostWrite(2'h2, 8'h1b);
        @(posedge clk);
        chk({3'h0, ackIrqEn, ctrlPinBits}, 8'h1b);
        printOne();
        hostRead(2'h1, d, oe);
        chk(d, 8'hdb);
        hostRead(2'h1, d, oe);
        chk(d, 8'hdf);
        // epp timeout: 99 waiting cycles are not enough, 100 are
        @(posedge clk);
        extModeSel <= 1'b0;
        eppEnable <= 1'b1;
        eppRevSel <= 1'b1;
        hostRead(2'h1, d, oe);
        chk(d, 8'hde);
        chk({7'h0, eppRev19}, 8'h01);
        @(posedge clk);
        eppWaitActive <= 1'b1;
        repeat (99) @(posedge clk);
        eppWaitActive <= 1'b0;
        hostRead(2'h1, d, oe);
        chk(d, 8'hde);
        @(posedge clk);
        eppWaitActive <= 1'b1;
        repeat (100) @(posedge clk);
        eppWaitActive <= 1'b0;
        hostRead(2'h1, d, oe);
        chk(d, 8'hdf);
        hostRead(2'h1, d, oe);
        chk(d, 8'hde);
        @(posedge clk);
        eppWaitActive <= 1'b1;
        repeat (110) @(posedge clk);
        eppWaitActive <= 1'b0;
        eppEnable <= 1'b0;
        @(posedge clk);
        eppEnable <= 1'b1;
        hostRead(2'h1, d, oe);
        chk(d, 8'hde);
        // ecp: bit two is constant until config bit 4 is set
        @(posedge clk);
        eppEnable <= 1'b0;
        ecpEnable <= 1'b1;
        printOne();
        hostRead(2'h1, d, oe);
        chk(d, 8'hdf);
        @(posedge clk);
        cfgIrqStatusEn <= 1'b1;
        printOne();
        hostRead(2'h1, d, oe);
        chk(d, 8'hdb);
        // a frozen port takes neither writes nor reads
        @(posedge clk);
        ce <= 1'b0;
        hostWrite(2'h0, 8'h77);
        hostRead(2'h0, d, oe);
        chk({7'h0, oe}, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        hostRead(2'h0, d, oe);
        chk(d, 8'h5a);
        chk(pdataPinsOut, 8'h5a);
        // reset in mid-run brings back the start values
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({3'h0, ackIrqEn, ctrlPinBits}, 8'h00);
        chk(pdataPinsOut, 8'h00);
        hostRead(2'h0, d, oe);
        chk(d, 8'h00);
        giveVerdict();
    end
endmodule : ppds_top_tb

`default_nettype wire
